// file: rtl/ibl_top.sv
// Bit-level bus interface: APB registers, pin control, mastership and watch timer.
`timescale 1ns/10ps
`include "ibl_consts.svh"
module ibl_top #(
   parameter int TMR_W = 10
) (
   input wire logic pclk, // System clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction.
   input wire logic [`IBL_ADDR_W-1:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire ibl_pkg::ibl_pins_t pins_i, // Bus pin levels.
   output ibl_pkg::ibl_pins_t pins_o, // Bus pin output values.
   output ibl_pkg::ibl_pins_t pins_oe, // Bus pin drive enables.
   output logic irq // Level interrupt.
);
   import ibl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.
   function automatic ibl_reg_t reg_of(input logic [`IBL_ADDR_W-1:0] a);
      case (a)
         `IBL_CFG_OFF: reg_of = IBL_R_CFG;
         `IBL_CTL_OFF: reg_of = IBL_R_CTL;
         `IBL_DAT_OFF: reg_of = IBL_R_DAT;
         `IBL_IST_OFF: reg_of = IBL_R_IST;
         `IBL_ICLR_OFF: reg_of = IBL_R_ICLR;
         `IBL_IEN_OFF: reg_of = IBL_R_IEN;
         default: reg_of = IBL_R_NONE;
      endcase
   endfunction

   ibl_mstate_t state_r;
   ibl_mstate_t state_nxt;
   ibl_pins_t pins_s;
   logic slave_enable_r;
   logic master_request_r;
   logic watch_timer_run_r;
   logic [1:0] scl_timing_sel_r;
   logic bit_data_ready_r;
   logic attention_flag_r;
   logic start_seen_r;
   logic stop_seen_r;
   logic busy_r;
   logic transmit_bit_r;
   logic sda_tx_r;
   logic rx_bit_r;
   logic scl_low_drv_r;
   logic scl_prev_r;
   logic sda_prev_r;
   logic [`IBL_INT_W-1:0] int_stat_r;
   logic [`IBL_INT_W-1:0] int_en_r;
   logic [`IBL_INT_W-1:0] int_set;
   logic [31:0] prdata_nxt;
   logic min_done;
   logic timeout;
   logic ovf_flag;

   wire ibl_reg_t cur_reg = reg_of(paddr);
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire wr_cfg = wr && (cur_reg == IBL_R_CFG);
   wire wr_ctl = wr && (cur_reg == IBL_R_CTL);
   wire wr_dat = wr && (cur_reg == IBL_R_DAT);
   wire wr_iclr = wr && (cur_reg == IBL_R_ICLR);
   wire wr_ien = wr && (cur_reg == IBL_R_IEN);

   assign pready = 1'b1;
   assign pslverr = access && (cur_reg == IBL_R_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and bus condition detection.
   ibl_sync #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(pins_i),
      .q(pins_s)
   );

   wire enabled = slave_enable_r || master_request_r;
   wire scl_rise = pins_s.scl && !scl_prev_r;
   wire scl_fall = !pins_s.scl && scl_prev_r;
   wire start_det = pins_s.scl && scl_prev_r && !pins_s.sda && sda_prev_r;
   wire stop_det = pins_s.scl && scl_prev_r && pins_s.sda && !sda_prev_r;
   wire mreq_rise = wr_cfg && pwdata[`IBL_CFG_MREQ] && !master_request_r;
   wire xstop_cmd = wr_ctl && pwdata[`IBL_CTL_XSTOP];
   wire own_reload = (state_nxt != state_r) && (state_nxt == IBL_M_START || state_nxt == IBL_M_STOPH);
   wire grant = (state_r == IBL_M_START) && min_done && !timeout;
   wire rdy_clr = wr_dat || (wr_ctl && pwdata[`IBL_CTL_CLRRDY]) || xstop_cmd;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
         busy_r <= 1'b0;
      end else begin
         scl_prev_r <= pins_s.scl;
         sda_prev_r <= pins_s.sda;
         busy_r <= start_det || (busy_r && !stop_det);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register.
   // A time-out outranks a software write that would set the enables again.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_enable_r <= 1'b0;
         master_request_r <= 1'b0;
         watch_timer_run_r <= 1'b0;
         scl_timing_sel_r <= 2'h0;
      end else begin
         if (timeout) begin
            slave_enable_r <= 1'b0;
            master_request_r <= 1'b0;
         end else if (wr_cfg) begin
            slave_enable_r <= pwdata[`IBL_CFG_SLV];
            master_request_r <= pwdata[`IBL_CFG_MREQ];
         end else if (state_r == IBL_M_STOPH && state_nxt == IBL_M_IDLE) begin
            master_request_r <= 1'b0;
         end
         if (wr_cfg) begin
            watch_timer_run_r <= pwdata[`IBL_CFG_RUN];
            scl_timing_sel_r <= pwdata[1:0];
         end
      end
   end

   ibl_watch_timer #(
      .WIDTH(TMR_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .run(watch_timer_run_r && enabled),
      .reload(scl_rise || scl_fall || own_reload),
      .sel(scl_timing_sel_r),
      .ovf_clr(wr_cfg && pwdata[`IBL_CFG_OVCLR]),
      .min_done(min_done),
      .timeout(timeout),
      .ovf_flag(ovf_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mastership sequencer.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IBL_M_IDLE: begin
            if (mreq_rise && busy_r) begin
               state_nxt = IBL_M_WAIT;
            end else if (mreq_rise) begin
               state_nxt = IBL_M_START;
            end
         end
         IBL_M_WAIT: begin
            if (!master_request_r) begin
               state_nxt = IBL_M_IDLE;
            end else if (stop_det) begin
               state_nxt = IBL_M_START;
            end
         end
         IBL_M_START: begin
            if (min_done) begin
               state_nxt = IBL_M_ACTIVE;
            end
         end
         IBL_M_ACTIVE: begin
            if (xstop_cmd) begin
               state_nxt = IBL_M_STOPL;
            end
         end
         IBL_M_STOPL: begin
            if (pins_s.scl) begin
               state_nxt = IBL_M_STOPH;
            end
         end
         IBL_M_STOPH: begin
            if (min_done) begin
               state_nxt = IBL_M_IDLE;
            end
         end
         default: state_nxt = IBL_M_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= IBL_M_IDLE;
      end else if (timeout) begin
         state_r <= IBL_M_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // As master, SCL goes low after the minimum high time and is released after
   // the minimum low time, but never while a bit is still waiting for software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_low_drv_r <= 1'b0;
      end else if (state_r == IBL_M_START) begin
         scl_low_drv_r <= min_done;
      end else if (state_r != IBL_M_ACTIVE) begin
         scl_low_drv_r <= 1'b0;
      end else if (pins_s.scl && min_done) begin
         scl_low_drv_r <= 1'b1;
      end else if (!pins_s.scl && min_done && !bit_data_ready_r) begin
         scl_low_drv_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit handshake with software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_data_ready_r <= 1'b0;
         attention_flag_r <= 1'b0;
         start_seen_r <= 1'b0;
         stop_seen_r <= 1'b0;
         transmit_bit_r <= 1'b1;
         rx_bit_r <= 1'b1;
      end else begin
         if ((enabled && scl_rise) || grant) begin
            bit_data_ready_r <= 1'b1;
         end else if (rdy_clr) begin
            bit_data_ready_r <= 1'b0;
         end
         if (grant || (enabled && (start_det || stop_det))) begin
            attention_flag_r <= 1'b1;
         end else if (wr_ctl && pwdata[`IBL_CTL_CLRATN]) begin
            attention_flag_r <= 1'b0;
         end
         if (enabled && start_det) begin
            start_seen_r <= 1'b1;
         end else if (wr_ctl && pwdata[`IBL_CTL_CLRATN]) begin
            start_seen_r <= 1'b0;
         end
         if (enabled && stop_det) begin
            stop_seen_r <= 1'b1;
         end else if (wr_ctl && pwdata[`IBL_CTL_CLRATN]) begin
            stop_seen_r <= 1'b0;
         end
         if (wr_dat) begin
            transmit_bit_r <= pwdata[`IBL_DAT_BIT];
         end
         if (scl_rise) begin
            rx_bit_r <= pins_s.sda;
         end
      end
   end

   // The written bit waits here until SCL is low, so an early answer can never
   // move SDA during the high phase and fake a start or stop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_tx_r <= 1'b1;
      end else if (!enabled) begin
         sda_tx_r <= 1'b1;
      end else if (!pins_s.scl) begin
         sda_tx_r <= transmit_bit_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive. Both pins are open drain: only ever driven low.
   wire sda_force = (state_r == IBL_M_START) || (state_r == IBL_M_STOPL) || (state_r == IBL_M_STOPH);
   wire scl_stretch = bit_data_ready_r && !pins_s.scl;
   wire scl_master = scl_low_drv_r || (state_r == IBL_M_STOPL && !min_done);

   assign pins_o = '0;
   assign pins_oe.scl = enabled && (scl_stretch || scl_master);
   assign pins_oe.sda = enabled && (sda_force || !sda_tx_r);

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and clear. A new event wins over its clear.
   assign int_set[`IBL_INT_RDY] = (enabled && scl_rise) || grant;
   assign int_set[`IBL_INT_TMO] = timeout;
   assign int_set[`IBL_INT_STOP] = enabled && stop_det;
   assign int_set[`IBL_INT_MAST] = grant;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= '0;
         int_en_r <= '0;
      end else begin
         int_stat_r <= int_set | (int_stat_r & ~(wr_iclr ? pwdata[`IBL_INT_W-1:0] : '0));
         if (wr_ien) begin
            int_en_r <= pwdata[`IBL_INT_W-1:0];
         end
      end
   end

   assign irq = |(int_stat_r & int_en_r);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup phase.
   wire master_now = (state_r == IBL_M_ACTIVE) || (state_r == IBL_M_STOPL);

   always_comb begin
      prdata_nxt = 32'h0000_0000;
      case (cur_reg)
         IBL_R_CFG: prdata_nxt[7:0] = {slave_enable_r, master_request_r, 1'b0, watch_timer_run_r,
                                       2'b00, scl_timing_sel_r};
         IBL_R_CTL: prdata_nxt[7:0] = {rx_bit_r, attention_flag_r, bit_data_ready_r, ovf_flag,
                                       start_seen_r, stop_seen_r, master_now, 1'b0};
         IBL_R_DAT: prdata_nxt[`IBL_DAT_BIT] = rx_bit_r;
         IBL_R_IST: prdata_nxt[`IBL_INT_W-1:0] = int_stat_r;
         IBL_R_IEN: prdata_nxt[`IBL_INT_W-1:0] = int_en_r;
         default: prdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= prdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_slave_on;
      @(posedge pclk) disable iff (!presetn)
      wr_cfg && pwdata[`IBL_CFG_SLV] && !timeout |=> slave_enable_r;
   endproperty
   a_slave_on: assert property (p_slave_on) else $error("slave enable not taken");

   wire irq_rdy_src = int_set[`IBL_INT_RDY] || int_set[`IBL_INT_STOP];
   property p_disabled_quiet;
      @(posedge pclk) disable iff (!presetn)
      !slave_enable_r && !master_request_r |-> !pins_oe.scl && !pins_oe.sda && !irq_rdy_src;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled interface drives bus");

   property p_timeout_clears;
      @(posedge pclk) disable iff (!presetn)
      timeout |=> !slave_enable_r && !master_request_r && state_r == IBL_M_IDLE;
   endproperty
   a_timeout_clears: assert property (p_timeout_clears) else $error("time-out left interface enabled");

   sequence s_req_busy;
      state_r == IBL_M_IDLE && mreq_rise && busy_r && !timeout;
   endsequence
   property p_defer;
      @(posedge pclk) disable iff (!presetn)
      s_req_busy |=> state_r == IBL_M_WAIT && !pins_oe.sda;
   endproperty
   a_defer: assert property (p_defer) else $error("mastership taken while bus busy");

   property p_grant;
      @(posedge pclk) disable iff (!presetn)
      grant |=> bit_data_ready_r && attention_flag_r && int_stat_r[`IBL_INT_MAST] && state_r == IBL_M_ACTIVE;
   endproperty
   a_grant: assert property (p_grant) else $error("start without ready, attention or event");

   property p_rdy_rise;
      @(posedge pclk) disable iff (!presetn)
      enabled && scl_rise |=> bit_data_ready_r;
   endproperty
   a_rdy_rise: assert property (p_rdy_rise) else $error("ready not set on SCL rise");

   property p_tx_low_phase;
      @(posedge pclk) disable iff (!presetn)
      enabled && !$stable(sda_tx_r) && $past(enabled) |-> !$past(pins_s.scl);
   endproperty
   a_tx_low_phase: assert property (p_tx_low_phase) else $error("SDA changed during SCL high");

   property p_stretch;
      @(posedge pclk) disable iff (!presetn)
      enabled && bit_data_ready_r && !pins_s.scl |-> pins_oe.scl;
   endproperty
   a_stretch: assert property (p_stretch) else $error("SCL released before service");

   property p_min_low;
      @(posedge pclk) disable iff (!presetn)
      state_r == IBL_M_ACTIVE && $fell(scl_low_drv_r) |-> $past(min_done) && !$past(bit_data_ready_r);
   endproperty
   a_min_low: assert property (p_min_low) else $error("SCL released before minimum low time");
endmodule

// file: rtl/ibl_consts.svh
// Constants of the bit-level bus interface: offsets, field positions, reset values and timing.
//
// Summary of operation
// - Setting slave_enable makes the interface answer as an addressed bus slave.
// - With slave_enable and master_request both zero the interface drives no pin and flags no bus event.
// - Reset and a watch timer time-out clear slave_enable.
// - Master request while bus busy waits for stop, then start, ready, attention, interrupt.
// - Timing select sets minimum SCL high and low time while master.
// - The same timing value paces start and stop generation.
// - bit_data_ready sets on every rising SCL edge while slave_enable or master_request is set.
// - A transmit bit reaches SDA only while SCL is low.
// - SCL is held low while bit_data_ready is unserviced.
// - Minimum SCL time is six CPU clocks times the selected count.
// - The watch timer is reloaded on every SCL transition while operating.
// - Reload value is eight minus the count; minimum time ends at eight.
`ifndef IBL_CONSTS_SVH
`define IBL_CONSTS_SVH
`define IBL_ADDR_W 12
`define IBL_CFG_OFF 12'h0c8
`define IBL_CTL_OFF 12'h0cc
`define IBL_DAT_OFF 12'h0d0
`define IBL_IST_OFF 12'h0d4
`define IBL_ICLR_OFF 12'h0d8
`define IBL_IEN_OFF 12'h0dc
`define IBL_CFG_RESET 8'h00
`define IBL_CFG_SLV 7
`define IBL_CFG_MREQ 6
`define IBL_CFG_OVCLR 5
`define IBL_CFG_RUN 4
`define IBL_CTL_CLRATN 7
`define IBL_CTL_CLRRDY 5
`define IBL_CTL_XSTOP 0
`define IBL_DAT_BIT 7
`define IBL_INT_W 4
`define IBL_INT_RDY 0
`define IBL_INT_TMO 1
`define IBL_INT_STOP 2
`define IBL_INT_MAST 3
`define IBL_MC_CLKS 6
`define IBL_MIN_REACHED 8
`define IBL_MIN_CNT0 10
`define IBL_MIN_CNT1 8
`define IBL_MIN_CNT2 7
`define IBL_MIN_CNT3 5
`endif

// file: rtl/ibl_pkg.sv
// Types shared by the bit-level bus interface.
package ibl_pkg;
   typedef struct packed {
      logic scl;
      logic sda;
   } ibl_pins_t;
   typedef enum logic [2:0] {
      IBL_M_IDLE = 3'h0,
      IBL_M_WAIT = 3'h1,
      IBL_M_START = 3'h3,
      IBL_M_ACTIVE = 3'h2,
      IBL_M_STOPL = 3'h6,
      IBL_M_STOPH = 3'h7
   } ibl_mstate_t;
   typedef enum logic [2:0] {
      IBL_R_NONE, IBL_R_CFG, IBL_R_CTL, IBL_R_DAT, IBL_R_IST, IBL_R_ICLR, IBL_R_IEN
   } ibl_reg_t;
endpackage

// file: rtl/ibl_sync.sv
// Two-stage synchroniser for the bus pins.
`timescale 1ns/10ps
module ibl_sync #(
   parameter int WIDTH = 2
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] d, // Asynchronous levels.
   output logic [WIDTH-1:0] q // Synchronised levels.
);
   logic [WIDTH-1:0] meta_r;
   // Idle bus lines are high, so reset to high avoids false edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '1;
         q <= '1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// file: rtl/ibl_watch_timer.sv
// Bus watch timer: minimum SCL phase measurement and time-out.
`timescale 1ns/10ps
`include "ibl_consts.svh"
module ibl_watch_timer #(
   parameter int WIDTH = 10
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic run, // Timer allowed to count.
   input wire logic reload, // SCL transition or own bus action.
   input wire logic [1:0] sel, // Timing select.
   input wire logic ovf_clr, // Clear the overflow flag.
   output logic min_done, // Minimum phase time has elapsed.
   output logic timeout, // One-cycle time-out pulse.
   output logic ovf_flag // Sticky overflow flag.
);
   logic [2:0] mc_r;
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] reload_val;
   logic [WIDTH-1:0] cnt_inc;
   wire mc_tick = run && (mc_r == 3'(`IBL_MC_CLKS - 1));

   function automatic logic [WIDTH-1:0] min_count(input logic [1:0] s);
      case (s)
         2'h0: min_count = WIDTH'(`IBL_MIN_CNT0);
         2'h1: min_count = WIDTH'(`IBL_MIN_CNT1);
         2'h2: min_count = WIDTH'(`IBL_MIN_CNT2);
         default: min_count = WIDTH'(`IBL_MIN_CNT3);
      endcase
   endfunction

   assign reload_val = WIDTH'(`IBL_MIN_REACHED) - min_count(sel);
   assign cnt_inc = cnt_r + WIDTH'(1);
   // A count above eight reloads below zero and passes all ones on its way to eight,
   // so only an expiry after the minimum time has elapsed is a time-out.
   assign timeout = mc_tick && !reload && min_done && (cnt_r == '1);

   // One machine cycle is six CPU clocks, so the minimum time is 6*count clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_r <= 3'h0;
      // Restarting the phase on reload keeps a minimum time from being cut short.
      end else if (!run || reload || mc_tick) begin
         mc_r <= 3'h0;
      end else begin
         mc_r <= mc_r + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         min_done <= 1'b0;
      end else if (!run) begin
         cnt_r <= '0;
         min_done <= 1'b0;
      end else if (reload) begin
         cnt_r <= reload_val;
         min_done <= 1'b0;
      end else if (mc_tick) begin
         cnt_r <= cnt_inc;
         if (cnt_inc == WIDTH'(`IBL_MIN_REACHED)) begin
            min_done <= 1'b1;
         end
      end
   end

   // Set wins over a clear written in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag <= 1'b0;
      end else if (timeout) begin
         ovf_flag <= 1'b1;
      end else if (ovf_clr) begin
         ovf_flag <= 1'b0;
      end
   end

   property p_reload_value;
      @(posedge pclk) disable iff (!presetn)
      run && reload |=> cnt_r == $past(reload_val);
   endproperty
   a_reload_value: assert property (p_reload_value) else $error("watch timer reload value wrong");

   property p_stop_clears;
      @(posedge pclk) disable iff (!presetn)
      !run |=> cnt_r == '0 && !min_done;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stopped watch timer not cleared");
endmodule

// file: testbench/ibl_bus_agent.sv
// Model of another bus agent with open-drain drivers on SCL and SDA.
`timescale 1ns/10ps
module ibl_bus_agent (
   input wire logic pclk, // Bench clock.
   output logic scl_oe, // High pulls SCL low.
   output logic sda_oe // High pulls SDA low.
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // A released line is never driven high here; the bench pull-up decides its level.
   task automatic set(input logic scl, input logic sda);
      @(posedge pclk);
      scl_oe <= ~scl;
      sda_oe <= ~sda;
   endtask
endmodule

// file: testbench/ibl_top_tb.sv
// Self-checking testbench of the bit-level bus interface.
`timescale 1ns/10ps
`include "ibl_consts.svh"
module ibl_top_tb;
   import ibl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err;
   logic a_scl_oe;
   logic a_sda_oe;
   ibl_pins_t pins_i;
   ibl_pins_t pins_o;
   ibl_pins_t pins_oe;
   logic irq;
   int mismatches = 0;
   int cmp_count = 0;
   int mc[4] = '{`IBL_MIN_CNT0, `IBL_MIN_CNT1, `IBL_MIN_CNT2, `IBL_MIN_CNT3};
   always #5 pclk = ~pclk;
   // Open-drain wired-AND with pull-ups on both lines.
   assign pins_i.scl = ~(pins_oe.scl | a_scl_oe);
   assign pins_i.sda = ~(pins_oe.sda | a_sda_oe);
   ibl_top #(.TMR_W(6)) u_ibl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins_i(pins_i), .pins_o(pins_o), .pins_oe(pins_oe), .irq(irq));
   ibl_bus_agent u_ibl_bus_agent (.pclk(pclk), .scl_oe(a_scl_oe), .sda_oe(a_sda_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Read data and error are taken only at the edge where pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the edge's register updates settle before any caller looks at outputs.
      @(negedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(0, `IBL_CFG_OFF, 32'h0000_0000);
      chk("cfg_reset", rd, 32'h0000_0000);
      apb(1, `IBL_CFG_OFF, 32'h0000_002d);
      apb(0, `IBL_CFG_OFF, 32'h0000_0000);
      chk("cfg_readback", rd, 32'h0000_0001);
      apb(0, 12'h0fc, 32'h0000_0000);
      chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
   endtask
   task automatic t_slave();
      apb(1, `IBL_CFG_OFF, 32'h0000_0080);
      apb(1, `IBL_IEN_OFF, 32'h0000_0001);
      u_ibl_bus_agent.set(1, 0);
      wt(8);
      u_ibl_bus_agent.set(0, 1);
      wt(8);
      u_ibl_bus_agent.set(1, 1);
      wt(8);
      chk("irq_on_rise", {31'h0, irq}, 32'h0000_0001);
      apb(1, `IBL_IEN_OFF, 32'h0000_0000);
      chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
      apb(1, `IBL_IEN_OFF, 32'h0000_0001);
      // The watch timer is not running here (run bit clear), so service has no deadline.
      apb(1, `IBL_DAT_OFF, 32'h0000_0000);
      wt(4);
      chk("sda_held_scl_high", {31'h0, pins_oe.sda}, 32'h0000_0000);
      u_ibl_bus_agent.set(0, 1);
      wt(8);
      chk("sda_after_fall", {31'h0, pins_oe.sda}, 32'h0000_0001);
      chk("no_stretch", {31'h0, pins_oe.scl}, 32'h0000_0000);
      apb(1, `IBL_ICLR_OFF, 32'h0000_000f);
      chk("irq_cleared", {31'h0, irq}, 32'h0000_0000);
      u_ibl_bus_agent.set(1, 1);
      wt(8);
      u_ibl_bus_agent.set(0, 1);
      wt(8);
      chk("stretch", {31'h0, pins_oe.scl}, 32'h0000_0001);
      apb(0, `IBL_DAT_OFF, 32'h0000_0000);
      chk("rx_bit", rd, 32'h0000_0000);
      apb(1, `IBL_DAT_OFF, 32'h0000_0080);
      wt(3);
      chk("stretch_end", {31'h0, pins_oe.scl}, 32'h0000_0000);
      chk("sda_released", {31'h0, pins_oe.sda}, 32'h0000_0000);
      apb(1, `IBL_CFG_OFF, 32'h0000_0000);
      u_ibl_bus_agent.set(1, 1);
      apb(1, `IBL_ICLR_OFF, 32'h0000_000f);
   endtask
   task automatic t_off();
      u_ibl_bus_agent.set(0, 1);
      wt(8);
      u_ibl_bus_agent.set(1, 1);
      wt(8);
      apb(0, `IBL_IST_OFF, 32'h0000_0000);
      chk("off_no_event", rd, 32'h0000_0000);
      chk("off_no_drive", {30'h0, pins_oe}, 32'h0000_0000);
      chk("pins_low_only", {30'h0, pins_o}, 32'h0000_0000);
   endtask
   // Every timing code is tried, as software would pick per clock rate.
   task automatic t_master();
      int n;
      for (int s = 0; s < 4; s++) begin
         u_ibl_bus_agent.set(1, 0);
         apb(1, `IBL_CFG_OFF, 32'h0000_00d0 | s);
         wt(100);
         chk("wait_for_stop", {31'h0, pins_oe.sda}, 32'h0000_0000);
         u_ibl_bus_agent.set(1, 1);
         n = 0;
         while (pins_oe.sda !== 1'b1 && n < 800) begin
            @(posedge pclk);
            n++;
         end
         chk("start_sda", {31'h0, n < 800}, 32'h0000_0001);
         n = 0;
         while (pins_oe.scl !== 1'b1 && n < 800) begin
            @(posedge pclk);
            n++;
         end
         chk("start_hold", {31'h0, n >= 6 * mc[s] && n <= 6 * mc[s] + 12}, 32'h0000_0001);
         apb(0, `IBL_IST_OFF, 32'h0000_0000);
         chk("granted", {31'h0, rd[`IBL_INT_MAST]}, 32'h0000_0001);
         wt(600);
         apb(0, `IBL_CFG_OFF, 32'h0000_0000);
         chk("timeout_cfg", rd, 32'h0000_0010 | s);
         apb(0, `IBL_IST_OFF, 32'h0000_0000);
         chk("timeout_flag", {31'h0, rd[`IBL_INT_TMO]}, 32'h0000_0001);
         apb(1, `IBL_ICLR_OFF, 32'h0000_000f);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_slave();
      t_off();
      t_master();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done();
   end
endmodule
